// *** hw/adcts_pkg.sv ***
// package: constants and carriers for the converter timing sequencer
package adcts_pkg;
   // control register layout: timing fields in the upper four bits
   localparam int unsigned CTRL_W        = 8;
   localparam int unsigned CTC_LSB       = 4;
   localparam int unsigned STC_LSB       = 6;
   localparam int unsigned RES_W         = 10;
   // conversion clock periods in clock phase units
   localparam logic [7:0]  CC_TCL_00     = 8'h18;
   localparam logic [7:0]  CC_TCL_10     = 8'h60;
   localparam logic [7:0]  CC_TCL_11     = 8'h30;
   // one core clock stands for one clock phase unit
   localparam logic [7:0]  TCL_PER_CLK   = 8'h01;
   localparam logic [3:0]  BIT_STEPS     = 4'ha;
   localparam logic [3:0]  EQ_STEPS      = 4'h4;
   localparam logic [1:0]  SAMPLE_CLKS   = 2'h2;
   localparam logic [3:0]  XFER_TCL      = 4'h4;
   localparam logic [RES_W-1:0] RES_ZERO = 10'h000;
   localparam logic [RES_W-1:0] RES_ONES = 10'h3ff;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_SAMPLE = 3'b001,
      ST_BITS   = 3'b010,
      ST_EQUAL  = 3'b011,
      ST_XFER   = 3'b100
   } adcts_state_e;

   // comparator view of the analog input
   typedef struct packed {
      logic             below_gnd;
      logic             above_ref;
      logic [RES_W-1:0] level;
   } adcts_ain_s;

   typedef struct packed {
      logic             valid;
      logic [RES_W-1:0] data;
   } adcts_result_s;
endpackage

// *** hw/adcts_sequencer.sv ***
// converter timing sequencer: sample, ten bit steps, equalise, result load
`timescale 1ns/100ps
// Notes on behaviour
// - a start first runs a sample phase before any bit decision
// - ten approximation steps follow, one conversion clock period each
// - four equalising periods follow, fourteen conversion periods overall
// - input changes after sampling ends do not affect the result
// - timing fields sit in control bits 7:4, two bits each
// - conversion clock 24, 96, 48 phase units for 00, 10, 11; 01 reserved
// - sample clock is conversion clock times 1, 2, 4 or 8
// - total is fourteen conversion periods, two sample periods, four phase units
// - the result register load ends every conversion within the total
// - below ground gives all zeros, above reference gives all ones
module adcts_sequencer (
   input  wire logic                            core_clk,
   input  wire logic                            rst,
   input  wire logic [adcts_pkg::CTRL_W-1:0]    converter_control_reg,
   input  wire logic                            start,
   input  wire adcts_pkg::adcts_ain_s           ain,
   output logic                                 busy,
   output logic                                 sampling,
   output adcts_pkg::adcts_result_s             result
);
   adcts_pkg::adcts_state_e state, next_state;
   logic [10:0]  cnt, next_cnt;
   logic [3:0]   step, next_step;
   logic [1:0]   cc_sel, next_cc_sel;
   logic [1:0]   sc_sel, next_sc_sel;
   adcts_pkg::adcts_ain_s held, next_held;
   adcts_pkg::adcts_result_s next_result;
   logic [7:0]   cc_period;
   logic [10:0]  sc_period;
   logic [1:0]   conv_clock_select;
   logic [1:0]   sample_clock_select;
   logic         cnt_done;

   // fields taken at start so a rewrite mid-conversion cannot bend timing
   assign conv_clock_select   = converter_control_reg[adcts_pkg::CTC_LSB +: 2];
   assign sample_clock_select = converter_control_reg[adcts_pkg::STC_LSB +: 2];

   always_comb begin
      case (cc_sel)
         2'h0:    cc_period = adcts_pkg::CC_TCL_00;
         2'h2:    cc_period = adcts_pkg::CC_TCL_10;
         2'h3:    cc_period = adcts_pkg::CC_TCL_11;
         // reserved code: fall back to the fastest setting
         default: cc_period = adcts_pkg::CC_TCL_00;
      endcase
   end
   assign sc_period = {3'h0, cc_period} << sc_sel;
   assign cnt_done  = (cnt == 11'h001);

   always_comb begin
      next_state  = state;
      next_cnt    = cnt;
      next_step   = step;
      next_cc_sel = cc_sel;
      next_sc_sel = sc_sel;
      next_held   = held;
      next_result = result;
      next_result.valid = 1'b0;
      case (state)
         adcts_pkg::ST_IDLE: begin
            if (start) begin
               next_cc_sel = conv_clock_select;
               next_sc_sel = sample_clock_select;
               next_state  = adcts_pkg::ST_SAMPLE;
               next_step   = 4'h0;
               next_cnt    = 11'h000;
            end
         end
         adcts_pkg::ST_SAMPLE: begin
            if (cnt == 11'h000) begin
               // two sample clock periods; this count-load cycle is already the
               // first of them, so one less is loaded to keep the total exact
               next_cnt = 11'((sc_period * 11'(adcts_pkg::SAMPLE_CLKS))
                              / 11'(adcts_pkg::TCL_PER_CLK)) - 11'h001;
            end else if (cnt_done) begin
               next_held  = ain;
               next_state = adcts_pkg::ST_BITS;
               next_cnt   = {3'h0, cc_period};
               next_step  = adcts_pkg::BIT_STEPS;
            end else begin
               next_cnt = cnt - 11'h001;
            end
         end
         adcts_pkg::ST_BITS, adcts_pkg::ST_EQUAL: begin
            if (cnt_done) begin
               next_cnt  = {3'h0, cc_period};
               next_step = step - 4'h1;
               if (step == 4'h1) begin
                  if (state == adcts_pkg::ST_BITS) begin
                     next_state = adcts_pkg::ST_EQUAL;
                     next_step  = adcts_pkg::EQ_STEPS;
                  end else begin
                     next_state = adcts_pkg::ST_XFER;
                     next_cnt   = {7'h00, adcts_pkg::XFER_TCL};
                  end
               end
            end else begin
               next_cnt = cnt - 11'h001;
            end
         end
         adcts_pkg::ST_XFER: begin
            if (cnt_done) begin
               next_state        = adcts_pkg::ST_IDLE;
               next_result.valid = 1'b1;
               if (held.below_gnd) begin
                  next_result.data = adcts_pkg::RES_ZERO;
               end else if (held.above_ref) begin
                  next_result.data = adcts_pkg::RES_ONES;
               end else begin
                  next_result.data = held.level;
               end
            end else begin
               next_cnt = cnt - 11'h001;
            end
         end
         default: next_state = adcts_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state  <= adcts_pkg::ST_IDLE;
         cnt    <= 11'h000;
         step   <= 4'h0;
         cc_sel <= 2'h0;
         sc_sel <= 2'h0;
         held   <= '0;
         result <= '0;
      end else begin
         state  <= next_state;
         cnt    <= next_cnt;
         step   <= next_step;
         cc_sel <= next_cc_sel;
         sc_sel <= next_sc_sel;
         held   <= next_held;
         result <= next_result;
      end
   end

   assign busy     = (state != adcts_pkg::ST_IDLE);
   assign sampling = (state == adcts_pkg::ST_SAMPLE);

   // checker counters: whole conversion length and cycles in the current phase
   logic [11:0]  len, next_len;
   logic [11:0]  phase_len, next_phase_len;

   always_comb begin
      next_len       = len + 12'h001;
      next_phase_len = phase_len + 12'h001;
      if (state == adcts_pkg::ST_IDLE) begin
         next_len = 12'h000;
      end
      // a phase change restarts the phase count; idle wrap is harmless
      if (next_state != state) begin
         next_phase_len = 12'h000;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         len       <= 12'h000;
         phase_len <= 12'h000;
      end else begin
         len       <= next_len;
         phase_len <= next_phase_len;
      end
   end

   sample_first_a: assert property (@(posedge core_clk) disable iff (rst)
      (state == adcts_pkg::ST_IDLE && start) |=> state == adcts_pkg::ST_SAMPLE)
      else $error("start did not enter sampling");
   bits_follow_a: assert property (@(posedge core_clk) disable iff (rst)
      $rose(state == adcts_pkg::ST_BITS) |->
      $past(state) == adcts_pkg::ST_SAMPLE && step == adcts_pkg::BIT_STEPS)
      else $error("bit step entered without sampling");
   bit_count_a: assert property (@(posedge core_clk) disable iff (rst)
      (state == adcts_pkg::ST_BITS && next_state == adcts_pkg::ST_EQUAL) |-> step == 4'h1)
      else $error("bit steps not ten");
   equal_count_a: assert property (@(posedge core_clk) disable iff (rst)
      $rose(state == adcts_pkg::ST_EQUAL) |-> step == adcts_pkg::EQ_STEPS)
      else $error("equalising steps not four");
   hold_input_a: assert property (@(posedge core_clk) disable iff (rst)
      (state == adcts_pkg::ST_BITS && $past(state) == adcts_pkg::ST_BITS) |-> $stable(held))
      else $error("held sample changed");
   total_len_a: assert property (@(posedge core_clk) disable iff (rst)
      result.valid |-> len == 12'((adcts_pkg::BIT_STEPS + adcts_pkg::EQ_STEPS) * cc_period
                                  + adcts_pkg::SAMPLE_CLKS * sc_period + adcts_pkg::XFER_TCL))
      else $error("conversion length wrong");
   // per-phase lengths, checked in the last cycle of each phase
   sample_len_a: assert property (@(posedge core_clk) disable iff (rst)
      (state == adcts_pkg::ST_SAMPLE && next_state == adcts_pkg::ST_BITS) |->
      phase_len == 12'(adcts_pkg::SAMPLE_CLKS * sc_period) - 12'h001)
      else $error("sample phase length wrong");
   bit_len_a: assert property (@(posedge core_clk) disable iff (rst)
      (state == adcts_pkg::ST_BITS && next_state == adcts_pkg::ST_EQUAL) |->
      phase_len == 12'(adcts_pkg::BIT_STEPS * cc_period) - 12'h001)
      else $error("bit phase length wrong");
   equal_len_a: assert property (@(posedge core_clk) disable iff (rst)
      (state == adcts_pkg::ST_EQUAL && next_state == adcts_pkg::ST_XFER) |->
      phase_len == 12'(adcts_pkg::EQ_STEPS * cc_period) - 12'h001)
      else $error("equalise phase length wrong");
   xfer_len_a: assert property (@(posedge core_clk) disable iff (rst)
      (state == adcts_pkg::ST_XFER && next_state == adcts_pkg::ST_IDLE) |->
      phase_len == 12'(adcts_pkg::XFER_TCL) - 12'h001)
      else $error("transfer phase length wrong");
   load_last_a: assert property (@(posedge core_clk) disable iff (rst)
      result.valid |-> $past(state) == adcts_pkg::ST_XFER && state == adcts_pkg::ST_IDLE)
      else $error("result loaded out of order");
   clamp_low_a: assert property (@(posedge core_clk) disable iff (rst)
      (result.valid && held.below_gnd) |-> result.data == adcts_pkg::RES_ZERO)
      else $error("underrange not zero");
   clamp_high_a: assert property (@(posedge core_clk) disable iff (rst)
      (result.valid && !held.below_gnd && held.above_ref) |->
      result.data == adcts_pkg::RES_ONES)
      else $error("overrange not all ones");
   busy_ignore_a: assert property (@(posedge core_clk) disable iff (rst)
      (busy && start && state != adcts_pkg::ST_XFER) |=> busy && state != adcts_pkg::ST_IDLE)
      else $error("start accepted while busy");
   fields_kept_a: assert property (@(posedge core_clk) disable iff (rst)
      (busy && start) |=> $stable(cc_sel) && $stable(sc_sel))
      else $error("fields relatched while busy");
   clk_sel_a: assert property (@(posedge core_clk) disable iff (rst)
      (busy && cc_sel == 2'h2) |-> cc_period == adcts_pkg::CC_TCL_10)
      else $error("conversion clock wrong");
   sample_mult_a: assert property (@(posedge core_clk) disable iff (rst)
      (busy && sc_sel == 2'h3) |-> sc_period == 11'({3'h0, cc_period} << 3))
      else $error("sample multiple wrong");
endmodule

// *** test/adcts_sequencer_test.sv ***
// testbench: conversion timing, sampling and result checks for the sequencer
`timescale 1ns/100ps
module adcts_sequencer_test;
   logic                     core_clk;
   logic                     rst;
   logic [7:0]               converter_control_reg;
   logic                     start;
   adcts_pkg::adcts_ain_s    ain;
   adcts_pkg::adcts_ain_s    a_v;
   logic                     busy;
   logic                     sampling;
   adcts_pkg::adcts_result_s result;
   int                       err_total;
   int                       comparisons;
   integer                   seed;

   adcts_sequencer u_dut (
      .core_clk              (core_clk),
      .rst                   (rst),
      .converter_control_reg (converter_control_reg),
      .start                 (start),
      .ain                   (ain),
      .busy                  (busy),
      .sampling              (sampling),
      .result                (result)
   );

   initial core_clk = 1'b0;
   always #2 core_clk = ~core_clk;

   // reserved code 01 runs like 00
   function automatic int conv_period(input logic [1:0] c);
      if (c == 2'b10) return int'(adcts_pkg::CC_TCL_10);
      if (c == 2'b11) return int'(adcts_pkg::CC_TCL_11);
      return int'(adcts_pkg::CC_TCL_00);
   endfunction

   function automatic logic [9:0] exp_data(input adcts_pkg::adcts_ain_s a);
      if (a.below_gnd) return adcts_pkg::RES_ZERO;
      if (a.above_ref) return adcts_pkg::RES_ONES;
      return a.level;
   endfunction

   task automatic chk_int(input string what, input int exp, input int got);
      comparisons++;
      if (exp != got) begin
         err_total++;
         $display("mismatch %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   task automatic chk_data(input string what, input logic [9:0] exp, input logic [9:0] got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic print_verdict;
      if (err_total == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // input and fields are scrambled once sampling ends; the result must not move
   task automatic run_conv(input logic [7:0] ctrl, input adcts_pkg::adcts_ain_s a, input bit poke);
      int n, s, low, cc, sc;
      cc = conv_period(ctrl[5:4]);
      sc = cc << ctrl[7:6];
      n = 0;
      s = 0;
      low = 0;
      converter_control_reg = ctrl;
      ain = a;
      start = 1'b1;
      @(posedge core_clk);
      #1;
      start = 1'b0;
      chk_int("sampling first", 1, int'(sampling === 1'b1));
      while (result.valid !== 1'b1 && n < 4000) begin
         if (sampling === 1'b1) s++;
         else if (s > 0) begin
            ain = ~a;
            converter_control_reg = ~ctrl;
         end
         if (busy !== 1'b1) low++;
         start = poke && (n == 60);
         @(posedge core_clk);
         #1;
         n++;
      end
      chk_int("latency", 14 * cc + 2 * sc + 4, n);
      chk_int("sample cycles", 2 * sc, s);
      chk_int("busy gaps", 0, low);
      chk_int("busy at load", 0, int'(busy !== 1'b0));
      chk_data("result", exp_data(a), result.data);
   endtask

   initial begin
      seed = 32'hcdf9e3d8;
      err_total = 0;
      comparisons = 0;
      rst = 1'b1;
      start = 1'b0;
      converter_control_reg = 8'h00;
      ain = '0;
      repeat (2) @(posedge core_clk);
      #1;
      chk_int("reset outputs", 0, int'({busy, sampling, result} !== '0));
      rst = 1'b0;
      for (int i = 0; i < 16; i++) begin
         a_v.level = 10'($random(seed));
         a_v.below_gnd = i[0];
         a_v.above_ref = i[1];
         run_conv({2'(i >> 2), 2'(i), 4'($random(seed))}, a_v, (i % 3) == 0);
      end
      for (int i = 0; i < 4; i++) begin
         a_v = 12'($random(seed));
         run_conv(8'($random(seed)), a_v, 1'b1);
      end
      converter_control_reg = 8'h00;
      start = 1'b1;
      @(posedge core_clk);
      #1;
      start = 1'b0;
      repeat (10) @(posedge core_clk);
      #1;
      rst = 1'b1;
      #1;
      chk_int("mid reset", 0, int'({busy, sampling, result} !== '0));
      @(posedge core_clk);
      #1;
      rst = 1'b0;
      a_v = 12'h0a5;
      run_conv(8'hf0, a_v, 1'b0);
      print_verdict;
   end

   // longest run is about 2.9k cycles
   initial begin
      #400000;
      err_total++;
      print_verdict;
   end
endmodule
